// ### common/cif_pkg.sv
package cif_pkg;

   // Register indices; the byte address on the bus is four times the index.
   localparam logic [3:0] IDX_SOURCE = 4'h3;
   localparam logic [3:0] IDX_ENABLE = 4'h4;
   localparam logic [3:0] IDX_LEVEL  = 4'h5;
   localparam logic [3:0] IDX_EVENTS = 4'h6;
   localparam logic [3:0] IDX_MASK   = 4'h7;

   // Field positions shared by the source, enable, event and mask registers.
   localparam int BIT_BUS_ERROR  = 7;
   localparam int BIT_ARB_LOST   = 6;
   localparam int BIT_ERR_PASS   = 5;
   localparam int BIT_WAKE_UP    = 4;
   localparam int BIT_OVERRUN    = 3;
   localparam int BIT_ERR_CHANGE = 2;
   localparam int BIT_TRANSMIT   = 1;
   localparam int BIT_RECEIVE    = 0;

   // Positions inside the watched status vector handed to the edge finder.
   localparam int WB_ERR_PASS = 0;
   localparam int WB_ERR_STAT = 1;
   localparam int WB_BUS_STAT = 2;
   localparam int WB_OVERRUN  = 3;
   localparam int WB_TX_BUF   = 4;
   localparam int WB_ACTIVITY = 5;
   localparam int WATCH_W     = 6;

   // Error counter limits.
   localparam logic [7:0] WARNING_LIMIT = 8'h60;
   localparam logic [7:0] PASSIVE_LIMIT = 8'h7f;

   // Reset values.
   localparam logic [7:0]  RST_SOURCE = 8'h00;
   localparam logic [7:0]  RST_ENABLE = 8'h00;
   localparam logic [7:0]  RST_LEVEL  = 8'h00;
   localparam logic [7:0]  RST_EVENTS = 8'h00;
   localparam logic [7:0]  RST_MASK   = 8'h00;
   localparam logic [31:0] RST_RDATA  = 32'h0000_0000;

endpackage

// ### rtl/cif_can_irq.sv
`timescale 1ns/1ps

// Functional notes
// RQ1 - Interrupt request is high exactly while any source flag is set.
// RQ2 - Reading the source register clears all flags except the receive flag. The code clears only the flags held in the captured read data.
// RQ3 - Source register is read-only; writes change no flag.
// RQ4 - Bus error flag sets on a bus error when its enable is on.
// RQ5 - After a bus error flag, further ones wait for an error capture read.
// RQ6 - Arbitration lost flag sets on lost arbitration when enabled.
// RQ7 - After arbitration lost, further ones wait for a capture register read.
// RQ8 - Error passive flag sets entering or leaving error passive (above 127).
// RQ9 - Wake-up flag sets on bus activity while sleeping, when enabled.
// RQ10 - Wake-up flag also sets on sleep attempt during activity or pending irq.
// RQ11 - Overrun flag sets only on a rising overrun status, when enabled.
// RQ12 - Error change flag sets on any change of error or bus status.
// RQ13 - Transmit flag sets when transmit buffer goes from locked to released.
// RQ14 - Receive flag sets on byte count above level or high-priority accept.
// RQ15 - High-priority accept sets receive flag at once; others wait for level.
// RQ16 - Release command clears receive flag; it returns if messages remain.
// RQ17 - Level check counts only bytes of complete messages.
// RQ18 - Error status is set when either counter reaches 96 or more.
// RQ19 - Reset clears every source flag so no request is pending.
module cif_can_irq #(
   parameter int CNT_W = 8
) (
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   input  wire logic [5:0]       avs_address,
   input  wire logic             avs_read,
   input  wire logic             avs_write,
   input  wire logic [31:0]      avs_writedata,
   input  wire logic [3:0]       avs_byteenable,
   output logic      [31:0]      avs_readdata,
   output logic                  avs_waitrequest,
   input  wire logic             bus_error_evt,
   input  wire logic             err_capture_read,
   input  wire logic             arb_lost_evt,
   input  wire logic             arb_capture_read,
   input  wire logic [7:0]       tx_err_count,
   input  wire logic [7:0]       rx_err_count,
   input  wire logic             bus_status,
   input  wire logic             sleeping,
   input  wire logic             bus_activity,
   input  wire logic             sleep_request,
   input  wire logic             data_overrun_status,
   input  wire logic             tx_buf_status,
   input  wire logic [CNT_W-1:0] rx_complete_bytes,
   input  wire logic [CNT_W-1:0] rx_msg_count,
   input  wire logic             hi_prio_accept,
   input  wire logic             release_rx_buf,
   output logic                  err_status,
   output logic                  can_irq,
   output logic                  event_irq
);

   initial begin
      if (CNT_W < 1 || CNT_W > 8) begin
         $error("cif_can_irq needs CNT_W between 1 and 8");
      end
   end

   ////////////////////////////////////////////////////////////////////////////

   logic [7:0]         can_interrupt_source;
   logic [7:0]         int_enable;
   logic [7:0]         receive_interrupt_level;
   logic [7:0]         event_log;
   logic [7:0]         event_mask;
   logic               ack;
   logic               take;
   logic               rd_take;
   logic               wr_take;
   logic [3:0]         index;
   logic               bus_error_lock;
   logic               arb_lost_lock;
   logic               rx_recheck;
   logic               err_passive;
   logic [7:0]         set_vec;
   logic [7:0]         clr_vec;
   logic [7:0]         next_source;
   logic [31:0]        next_rdata;
   logic [cif_pkg::WATCH_W-1:0] watch;
   logic [cif_pkg::WATCH_W-1:0] rise;
   logic [cif_pkg::WATCH_W-1:0] fall;
   logic [7:0]         complete_bytes;
   logic [7:0]         msgs_left;

   function automatic logic counters_reach(input logic [7:0] a,
                                           input logic [7:0] b,
                                           input logic [7:0] lim);
      counters_reach = (a >= lim) || (b >= lim);
   endfunction

   function automatic logic changed(input int pos,
                                    input logic [cif_pkg::WATCH_W-1:0] r,
                                    input logic [cif_pkg::WATCH_W-1:0] f);
      changed = r[pos] | f[pos];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Avalon slave: every request waits one cycle, then completes.

   assign avs_waitrequest = (avs_read | avs_write) & ~ack;
   assign take            = (avs_read | avs_write) & ack;
   assign rd_take         = take & avs_read;
   assign wr_take         = take & avs_write & avs_byteenable[0];
   assign index           = avs_address[5:2];

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ack <= 1'b0;
      end else begin
         ack <= (avs_read | avs_write) & ~ack;
      end
   end

   always_comb begin
      next_rdata = 32'h0000_0000;
      unique case (index)
         cif_pkg::IDX_SOURCE: next_rdata[7:0] = can_interrupt_source;
         cif_pkg::IDX_ENABLE: next_rdata[7:0] = int_enable;
         cif_pkg::IDX_LEVEL:  next_rdata[7:0] = receive_interrupt_level;
         cif_pkg::IDX_EVENTS: next_rdata[7:0] = event_log;
         cif_pkg::IDX_MASK:   next_rdata[7:0] = event_mask;
         default:             next_rdata = 32'h0000_0000;
      endcase
   end

   // Read data are captured one edge early and stand while waitrequest is low.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         avs_readdata <= cif_pkg::RST_RDATA;
      end else if (avs_read && !ack) begin
         avs_readdata <= next_rdata;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         int_enable              <= cif_pkg::RST_ENABLE;
         receive_interrupt_level <= cif_pkg::RST_LEVEL;
         event_mask              <= cif_pkg::RST_MASK;
      end else if (wr_take) begin
         if (index == cif_pkg::IDX_ENABLE) begin
            int_enable <= avs_writedata[7:0];
         end
         if (index == cif_pkg::IDX_LEVEL) begin
            receive_interrupt_level <= avs_writedata[7:0];
         end
         if (index == cif_pkg::IDX_MASK) begin
            event_mask <= avs_writedata[7:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status levels and their changes.

   assign err_status  = counters_reach(tx_err_count, rx_err_count,
                                       cif_pkg::WARNING_LIMIT); // see RQ18
   assign err_passive = (tx_err_count > cif_pkg::PASSIVE_LIMIT) ||
                        (rx_err_count > cif_pkg::PASSIVE_LIMIT); // see RQ8

   always_comb begin
      watch = '0;
      watch[cif_pkg::WB_ERR_PASS] = err_passive;
      watch[cif_pkg::WB_ERR_STAT] = err_status;
      watch[cif_pkg::WB_BUS_STAT] = bus_status;
      watch[cif_pkg::WB_OVERRUN]  = data_overrun_status;
      watch[cif_pkg::WB_TX_BUF]   = tx_buf_status;
      watch[cif_pkg::WB_ACTIVITY] = bus_activity;
   end

   cif_edge_det #(
      .W       (cif_pkg::WATCH_W)
   ) u_edges (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .level   (watch),
      .rise    (rise),
      .fall    (fall)
   );

   assign complete_bytes = 8'(rx_complete_bytes);
   assign msgs_left      = 8'(rx_msg_count);

   ////////////////////////////////////////////////////////////////////////////
   // Event set terms, each gated by its enable.

   always_comb begin
      set_vec = 8'h00;
      set_vec[cif_pkg::BIT_BUS_ERROR] = bus_error_evt && !bus_error_lock &&
         int_enable[cif_pkg::BIT_BUS_ERROR]; // see RQ4 see RQ5
      set_vec[cif_pkg::BIT_ARB_LOST] = arb_lost_evt && !arb_lost_lock &&
         int_enable[cif_pkg::BIT_ARB_LOST]; // see RQ6 see RQ7
      set_vec[cif_pkg::BIT_ERR_PASS] = int_enable[cif_pkg::BIT_ERR_PASS] &&
         changed(cif_pkg::WB_ERR_PASS, rise, fall); // see RQ8
      set_vec[cif_pkg::BIT_WAKE_UP] = int_enable[cif_pkg::BIT_WAKE_UP] &&
         ((sleeping && rise[cif_pkg::WB_ACTIVITY]) || // see RQ9
          (sleep_request && (bus_activity || can_irq))); // see RQ10
      set_vec[cif_pkg::BIT_OVERRUN] = int_enable[cif_pkg::BIT_OVERRUN] &&
         rise[cif_pkg::WB_OVERRUN]; // see RQ11
      set_vec[cif_pkg::BIT_ERR_CHANGE] = int_enable[cif_pkg::BIT_ERR_CHANGE] &&
         (changed(cif_pkg::WB_ERR_STAT, rise, fall) ||
          changed(cif_pkg::WB_BUS_STAT, rise, fall)); // see RQ12
      set_vec[cif_pkg::BIT_TRANSMIT] = int_enable[cif_pkg::BIT_TRANSMIT] &&
         rise[cif_pkg::WB_TX_BUF]; // see RQ13
      // Only bytes of complete messages are counted against the level.
      // During a release the counts still hold the message being freed, so
      // the level term waits for the recheck cycle; otherwise the flag could
      // outlive the last message in the store.
      set_vec[cif_pkg::BIT_RECEIVE] = int_enable[cif_pkg::BIT_RECEIVE] &&
         (hi_prio_accept || // see RQ15
          (!release_rx_buf &&
           complete_bytes > receive_interrupt_level) || // see RQ14 see RQ17
          (rx_recheck && msgs_left != 8'h00)); // see RQ16
   end

   // Only bits that the reader actually saw are cleared, so a flag raised
   // between the capture of the read data and the completing edge survives.
   always_comb begin
      clr_vec = 8'h00;
      if (rd_take && index == cif_pkg::IDX_SOURCE) begin
         clr_vec[7:1] = avs_readdata[7:1]; // see RQ2
      end
      clr_vec[cif_pkg::BIT_RECEIVE] = release_rx_buf; // see RQ16
      // Writes never reach the source register. see RQ3
      next_source = (can_interrupt_source & ~clr_vec) | set_vec;
   end

   ////////////////////////////////////////////////////////////////////////////

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         can_interrupt_source <= cif_pkg::RST_SOURCE; // see RQ19
      end else begin
         can_interrupt_source <= next_source;
      end
   end

   // The receive flag is looked at again the cycle after a release, once
   // the message count reflects the freed buffer.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rx_recheck <= 1'b0;
      end else begin
         rx_recheck <= release_rx_buf; // see RQ16
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         bus_error_lock <= 1'b0;
      end else if (set_vec[cif_pkg::BIT_BUS_ERROR]) begin
         bus_error_lock <= 1'b1; // see RQ5
      end else if (err_capture_read) begin
         bus_error_lock <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         arb_lost_lock <= 1'b0;
      end else if (set_vec[cif_pkg::BIT_ARB_LOST]) begin
         arb_lost_lock <= 1'b1; // see RQ7
      end else if (arb_capture_read) begin
         arb_lost_lock <= 1'b0;
      end
   end

   // Sticky log of enabled events, cleared by writing ones; set wins.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         event_log <= cif_pkg::RST_EVENTS;
      end else if (wr_take && index == cif_pkg::IDX_EVENTS) begin
         event_log <= (event_log & ~avs_writedata[7:0]) | set_vec;
      end else begin
         event_log <= event_log | set_vec;
      end
   end

   assign can_irq   = |can_interrupt_source; // see RQ1
   assign event_irq = |(event_log & event_mask);

   ////////////////////////////////////////////////////////////////////////////

   logic src_read;
   assign src_read = rd_take && index == cif_pkg::IDX_SOURCE;

   a_irq_cause: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(can_irq) |-> $past(set_vec) != 8'h00) // see RQ1
      else $error("interrupt request rose without an event");

   a_read_clears: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (src_read && set_vec[7:1] == 7'h00) |=>
         (can_interrupt_source[7:1] & $past(avs_readdata[7:1])) == 7'h00)
      else $error("read of source register left a seen flag set"); // see RQ2

   a_read_keeps_rx: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (src_read && !release_rx_buf && can_interrupt_source[0]) |=>
         can_interrupt_source[0]) // see RQ2
      else $error("read cleared the receive flag");

   a_write_ignored: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (wr_take && index == cif_pkg::IDX_SOURCE && set_vec == 8'h00 &&
       !release_rx_buf) |=> $stable(can_interrupt_source)) // see RQ3
      else $error("write changed the source register");

   a_be_locked: assert property (@(posedge clk_sys) disable iff (!rst_n)
      set_vec[7] ##1 (!err_capture_read)[*2] |-> !set_vec[7]) // see RQ5
      else $error("bus error flag raised while locked");

   a_al_locked: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (set_vec[6] ##1 arb_lost_evt && !arb_capture_read) |-> !set_vec[6])
      else $error("arbitration lost raised while locked"); // see RQ7

   a_ovr_rise: assert property (@(posedge clk_sys) disable iff (!rst_n)
      set_vec[3] |-> $rose(data_overrun_status) && int_enable[3]) // see RQ11
      else $error("overrun flag set without a rising status");

   a_tx_release: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (int_enable[1] && $rose(tx_buf_status)) |=>
         can_interrupt_source[1] && can_irq) // see RQ13
      else $error("transmit release did not raise the flag");

   a_hi_prio: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (int_enable[0] && hi_prio_accept) |=> can_interrupt_source[0])
      else $error("high priority accept did not raise receive"); // see RQ15

   a_rx_release: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (release_rx_buf && !set_vec[0]) |=> !can_interrupt_source[0]) // see RQ16
      else $error("release did not clear the receive flag");

   a_err_change: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (int_enable[2] && $changed(bus_status)) |=> can_interrupt_source[2])
      else $error("bus status change left error flag clear"); // see RQ12

   c_read_clear: cover property (@(posedge clk_sys) disable iff (!rst_n)
      src_read && avs_readdata[7:1] != 7'h00);

   c_release_again: cover property (@(posedge clk_sys) disable iff (!rst_n)
      release_rx_buf ##1 set_vec[0] ##1 can_interrupt_source[0]);

   c_sleep_wake: cover property (@(posedge clk_sys) disable iff (!rst_n)
      sleep_request && can_irq ##1 can_interrupt_source[4]);

endmodule

// ### rtl/cif_edge_det.sv
`timescale 1ns/1ps

// Finds rising and falling changes of a vector of status levels.
module cif_edge_det #(
   parameter int W = 6
) (
   input  wire logic         clk_sys,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] level,
   output logic      [W-1:0] rise,
   output logic      [W-1:0] fall
);

   logic [W-1:0] prev;

   initial begin
      if (W < 1) begin
         $error("cif_edge_det needs W of at least 1");
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         prev <= '0;
      end else begin
         prev <= level;
      end
   end

   assign rise = level & ~prev;
   assign fall = ~level & prev;

endmodule

// ### test/cif_rx_fifo_model.sv
`timescale 1ns/1ps

// Receive store holding whole messages only, so the byte count it reports
// never includes a frame that is still arriving.
module cif_rx_fifo_model #(
   parameter int CNT_W = 8
) (
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   input  wire logic             push,
   input  wire logic [7:0]       push_len,
   input  wire logic             release_rx_buf,
   output logic      [CNT_W-1:0] rx_msg_count,
   output logic      [CNT_W-1:0] rx_complete_bytes
);
   int q[$];
   int sum;

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         q.delete();
      end else begin
         if (release_rx_buf && q.size() != 0) begin
            void'(q.pop_front());
         end
         if (push) begin
            q.push_back(int'(push_len));
         end
      end
      sum = 0;
      foreach (q[i]) begin
         sum += q[i];
      end
      rx_msg_count <= CNT_W'(q.size());
      rx_complete_bytes <= CNT_W'(sum);
   end
endmodule

// ### test/tb_cif_can_irq.sv
`timescale 1ns/1ps

module tb_cif_can_irq;
   logic        clk_sys = 1'b0;
   logic        rst_n = 1'b0;
   logic [5:0]  avs_address = 6'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0]  avs_byteenable = 4'hf;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        bus_error_evt = 1'b0;
   logic        err_capture_read = 1'b0;
   logic        arb_lost_evt = 1'b0;
   logic        arb_capture_read = 1'b0;
   logic [7:0]  tx_err_count = 8'h00;
   logic [7:0]  rx_err_count = 8'h00;
   logic        bus_status = 1'b0;
   logic        sleeping = 1'b1;
   logic        bus_activity = 1'b0;
   logic        sleep_request = 1'b0;
   logic        data_overrun_status = 1'b0;
   logic        tx_buf_status = 1'b0;
   logic [7:0]  rx_complete_bytes;
   logic [7:0]  rx_msg_count;
   logic        hi_prio_accept = 1'b0;
   logic        release_rx_buf = 1'b0;
   logic        push = 1'b0;
   logic [7:0]  push_len = 8'h00;
   logic        err_status;
   logic        can_irq;
   logic        event_irq;
   logic [7:0]  rd;
   int          n_fail = 0;
   int          checked = 0;
   int          cycles = 0;
   int          exp_src = 0;
   int          lvl;

   cif_can_irq #(.CNT_W(8)) cif_can_irq_inst (
      .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .bus_error_evt(bus_error_evt), .err_capture_read(err_capture_read),
      .arb_lost_evt(arb_lost_evt), .arb_capture_read(arb_capture_read),
      .tx_err_count(tx_err_count), .rx_err_count(rx_err_count),
      .bus_status(bus_status), .sleeping(sleeping),
      .bus_activity(bus_activity), .sleep_request(sleep_request),
      .data_overrun_status(data_overrun_status),
      .tx_buf_status(tx_buf_status), .rx_complete_bytes(rx_complete_bytes),
      .rx_msg_count(rx_msg_count), .hi_prio_accept(hi_prio_accept),
      .release_rx_buf(release_rx_buf), .err_status(err_status),
      .can_irq(can_irq), .event_irq(event_irq));

   cif_rx_fifo_model #(.CNT_W(8)) cif_rx_fifo_model_inst (
      .clk_sys(clk_sys), .rst_n(rst_n), .push(push), .push_len(push_len),
      .release_rx_buf(release_rx_buf), .rx_msg_count(rx_msg_count),
      .rx_complete_bytes(rx_complete_bytes));

   always #5 clk_sys = ~clk_sys;

   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_fail++;
         final_report();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input string s, input logic [7:0] got, input int e);
      checked++;
      if (got !== 8'(e)) begin
         n_fail++;
         $display("[FAIL] %s expected %0h seen %0h", s, 8'(e), got);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   // The request stands until the rising edge at which waitrequest is seen
   // low; read data are taken at that edge, before its own updates land.
   // Only the bench timeout ends a wait that never completes.
   task automatic bus(input logic w, input logic [5:0] a,
                      input logic [7:0] d, output logic [7:0] q);
      @(posedge clk_sys);
      avs_address <= a;
      avs_write <= w;
      avs_read <= ~w;
      avs_writedata <= {24'h0, d};
      do begin
         @(posedge clk_sys);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      bus(1'b1, a, d, rd);
   endtask

   // Reading clears every modelled flag except the receive one.
   task automatic check_src();
      @(negedge clk_sys);
      chk("can_irq", {7'h00, can_irq}, int'(exp_src != 0));
      bus(1'b0, 6'h0c, 8'h00, rd);
      chk("source", rd, exp_src);
      exp_src = exp_src & 1;
   endtask

   task automatic fire(input int b);
      step(1);
      case (b)
         7: bus_error_evt <= 1'b1;
         6: arb_lost_evt <= 1'b1;
         5: tx_err_count <= tx_err_count ^ 8'h80;
         4: bus_activity <= 1'b1;
         3: data_overrun_status <= 1'b1;
         2: bus_status <= ~bus_status;
         1: tx_buf_status <= 1'b1;
         default: hi_prio_accept <= 1'b1;
      endcase
      step(1);
      hi_prio_accept <= 1'b0;
      {bus_activity, data_overrun_status, tx_buf_status} <= 3'b000;
      // Bus error and lost arbitration last three cycles, so the lock has
      // to hold back the repeats.
      step(2);
      {bus_error_evt, arb_lost_evt} <= 2'b00;
      step(1);
   endtask

   task automatic counters(input logic [7:0] t, input logic [7:0] r,
                           input int es);
      step(1);
      tx_err_count <= t;
      rx_err_count <= r;
      step(3);
      @(negedge clk_sys);
      chk("err_status", {7'h00, err_status}, es);
   endtask

   task automatic rx_op(input int n);
      step(1);
      release_rx_buf <= (n < 0);
      push <= (n >= 0);
      push_len <= 8'(n);
      step(1);
      {release_rx_buf, push} <= 2'b00;
      step(3);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(22));
      step(2);
      rst_n <= 1'b1;
      check_src();
      wr(6'h10, 8'h5a);
      bus(1'b0, 6'h10, 8'h00, rd);
      chk("enable", rd, 8'h5a);
      wr(6'h0c, 8'hff);
      check_src();
      bus(1'b0, 6'h3c, 8'h00, rd);
      chk("unmapped", rd, 0);
      $display("test registers done");
      for (int b = 0; b < 8; b++) begin
         wr(6'h10, 8'h00);
         fire(b);
         check_src();
         wr(6'h10, 8'(1 << b));
         fire(b);
         exp_src = exp_src | (1 << b);
         check_src();
      end
      for (int b = 6; b < 8; b++) begin
         wr(6'h10, 8'(1 << b));
         fire(b);
         check_src();
         {err_capture_read, arb_capture_read} <= (b == 7) ? 2'b10 : 2'b01;
         step(1);
         {err_capture_read, arb_capture_read} <= 2'b00;
         fire(b);
         exp_src = exp_src | (1 << b);
         check_src();
      end
      $display("test sources done");
      wr(6'h10, 8'h24);
      counters(8'($urandom_range(0, 95)), 8'h5f, 0);
      check_src();
      counters(8'h60, 8'h7f, 1);
      exp_src = exp_src | 8'h04;
      check_src();
      counters(8'h60, 8'h80, 1);
      exp_src = exp_src | 8'h20;
      check_src();
      counters(8'h00, 8'h00, 0);
      exp_src = exp_src | 8'h24;
      check_src();
      $display("test error counters done");
      wr(6'h10, 8'h12);
      sleeping <= 1'b0;
      for (int k = 0; k < 2; k++) begin
         if (k == 0) begin
            fire(1);
         end
         bus_activity <= (k == 1);
         step(2);
         sleep_request <= 1'b1;
         step(1);
         sleep_request <= 1'b0;
         exp_src = exp_src | 8'h10 | (k == 0 ? 2 : 0);
         check_src();
      end
      $display("test sleep attempt done");
      lvl = $urandom_range(1, 20);
      wr(6'h14, 8'(lvl));
      wr(6'h10, 8'h01);
      rx_op(-1);
      exp_src = 0;
      check_src();
      rx_op(lvl);
      check_src();
      rx_op($urandom_range(1, 8));
      exp_src = 1;
      check_src();
      rx_op(-1);
      check_src();
      rx_op(-1);
      exp_src = 0;
      check_src();
      hi_prio_accept <= 1'b1;
      step(1);
      hi_prio_accept <= 1'b0;
      @(negedge clk_sys);
      chk("can_irq", {7'h00, can_irq}, 1);
      exp_src = 1;
      $display("test receive done");
      wr(6'h10, 8'h02);
      wr(6'h18, 8'hff);
      wr(6'h1c, 8'h02);
      fire(1);
      @(negedge clk_sys);
      chk("event_irq", {7'h00, event_irq}, 1);
      wr(6'h18, 8'h02);
      @(negedge clk_sys);
      chk("event_irq", {7'h00, event_irq}, 0);
      wr(6'h1c, 8'h00);
      fire(1);
      bus(1'b0, 6'h18, 8'h00, rd);
      chk("event_log", rd, 8'h02);
      chk("event_irq", {7'h00, event_irq}, 0);
      $display("test event log done");
      rst_n <= 1'b0;
      step(2);
      chk("can_irq", {7'h00, can_irq}, 0);
      rst_n <= 1'b1;
      exp_src = 0;
      check_src();
      $display("test mid reset done");
      final_report();
   end
endmodule
